// ===== shared/relay_defs.svh
`ifndef RELAY_DEFS_SVH
`define RELAY_DEFS_SVH
// ****************************************************************
// timing
// ****************************************************************
`define CLK_HZ 25000000
`define SUPPLY_LOSS_MS 20
`define SUPPLY_LOSS_CYC ((`SUPPLY_LOSS_MS * (`CLK_HZ / 1000)) + 1)
`define POWER_OFF_MS 1000
`define POWER_OFF_CYC (`POWER_OFF_MS * (`CLK_HZ / 1000))
`define DIGIT_FLASH_MS 1000
`define DIGIT_FLASH_CYC (`DIGIT_FLASH_MS * (`CLK_HZ / 1000))
`define SHORT_FLASH_MS 200
`define SHORT_FLASH_CYC (`SHORT_FLASH_MS * (`CLK_HZ / 1000))
`define PREAMBLE_PAUSE_MS 2000
`define PREAMBLE_PAUSE_CYC (`PREAMBLE_PAUSE_MS * (`CLK_HZ / 1000))
`define DIGIT_GAP_MS 3000
`define DIGIT_GAP_CYC (`DIGIT_GAP_MS * (`CLK_HZ / 1000))
`define BLINK_HALF_MS 250
`define BLINK_HALF_CYC (`BLINK_HALF_MS * (`CLK_HZ / 1000))
`define INIT_MS 500
`define INIT_CYC (`INIT_MS * (`CLK_HZ / 1000))
`define TEST_PERIOD_MS 10
`define TEST_PERIOD_CYC (`TEST_PERIOD_MS * (`CLK_HZ / 1000))
`define TEST_PULSE_CYC 25
// ****************************************************************
// flash code layout
// ****************************************************************
`define PREAMBLE_COUNT 3
`define MAX_DIGITS 4
`define ZERO_FLASHES 16
`define SUPPLY_ERR_CODE 16'h0082
`define SUPPLY_ERR_LEN 3'h2
`endif

// ===== shared/relay_pkg.sv
package relay_pkg;
    typedef enum logic [2:0] {
        ST_INIT, ST_WAIT_START, ST_RUN, ST_ALT, ST_CODE, ST_LOCKED
    } mode_t;
    typedef enum logic [2:0] {
        FS_IDLE, FS_PRE_ON, FS_PRE_OFF, FS_PAUSE, FS_DIG_ON, FS_DIG_OFF, FS_GAP
    } flash_t;
    typedef struct packed {
        logic power;
        logic ch1;
        logic ch2;
    } leds_t;
    typedef struct packed {
        logic [15:0] code; // four bcd digits, most significant first
        logic [2:0] len;   // 1 to 4 digits
    } err_code_t;
endpackage

// ===== verilog/flash_coder.sv
`timescale 1ns/1ps
`include "relay_defs.svh"
module flash_coder #(
    parameter int unsigned SHORT_CYC = `SHORT_FLASH_CYC,
    parameter int unsigned PAUSE_CYC = `PREAMBLE_PAUSE_CYC,
    parameter int unsigned GAP_CYC = `DIGIT_GAP_CYC,
    parameter int unsigned DIGIT_CYC = `DIGIT_FLASH_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire relay_pkg::err_code_t err,
    output logic led,
    output logic frame_start
);
    typedef struct packed {
        relay_pkg::flash_t st;
        logic [31:0] tmr;
        logic [4:0] cnt;
        logic [1:0] dig;
        logic led;
    } fc_t;
    fc_t s, n;
    logic [3:0] digit_val;
    logic [4:0] flashes;

    // digit selection, zero shown as sixteen flashes
    always_comb begin
        digit_val = err.code[4'(4'd15 - {s.dig, 2'b00}) -: 4];
        flashes = (digit_val == 4'h0) ? 5'(`ZERO_FLASHES) : {1'b0, digit_val};
    end

    // flash sequencer: preamble, pause, digits with gaps, repeat
    always_comb begin
        n = s;
        frame_start = 1'b0;
        if (s.tmr != 32'h0) begin
            n.tmr = s.tmr - 32'h1;
        end
        unique case (s.st)
            relay_pkg::FS_IDLE: begin
                n.led = 1'b0;
                if (run) begin
                    frame_start = 1'b1;
                    n.st = relay_pkg::FS_PRE_ON;
                    n.tmr = SHORT_CYC - 1;
                    n.cnt = 5'h0;
                    n.led = 1'b1;
                end
            end
            relay_pkg::FS_PRE_ON: if (s.tmr == 32'h0) begin
                n.st = relay_pkg::FS_PRE_OFF;
                n.tmr = SHORT_CYC - 1;
                n.led = 1'b0;
                n.cnt = s.cnt + 5'h1;
            end
            relay_pkg::FS_PRE_OFF: if (s.tmr == 32'h0) begin
                if (s.cnt == 5'(`PREAMBLE_COUNT)) begin
                    n.st = relay_pkg::FS_PAUSE;
                    n.tmr = PAUSE_CYC - 1;
                end else begin
                    n.st = relay_pkg::FS_PRE_ON;
                    n.tmr = SHORT_CYC - 1;
                    n.led = 1'b1;
                end
            end
            relay_pkg::FS_PAUSE: if (s.tmr == 32'h0) begin
                n.st = relay_pkg::FS_DIG_ON;
                n.tmr = DIGIT_CYC / 2 - 1;
                n.led = 1'b1;
                n.cnt = 5'h0;
                n.dig = 2'h0;
            end
            relay_pkg::FS_DIG_ON: if (s.tmr == 32'h0) begin
                n.st = relay_pkg::FS_DIG_OFF;
                n.tmr = DIGIT_CYC - DIGIT_CYC / 2 - 1;
                n.led = 1'b0;
                n.cnt = s.cnt + 5'h1;
            end
            relay_pkg::FS_DIG_OFF: if (s.tmr == 32'h0) begin
                if (s.cnt == flashes) begin
                    n.st = relay_pkg::FS_GAP;
                    n.tmr = GAP_CYC - 1;
                end else begin
                    n.st = relay_pkg::FS_DIG_ON;
                    n.tmr = DIGIT_CYC / 2 - 1;
                    n.led = 1'b1;
                end
            end
            relay_pkg::FS_GAP: if (s.tmr == 32'h0) begin
                if (3'({1'b0, s.dig} + 3'h1) >= err.len || s.dig == 2'(`MAX_DIGITS - 1)) begin
                    n.st = relay_pkg::FS_IDLE;
                end else begin
                    n.st = relay_pkg::FS_DIG_ON;
                    n.dig = s.dig + 2'h1;
                    n.cnt = 5'h0;
                    n.tmr = DIGIT_CYC / 2 - 1;
                    n.led = 1'b1;
                end
            end
            default: n.st = relay_pkg::FS_IDLE;
        endcase
        if (!run) begin
            n.st = relay_pkg::FS_IDLE;
            n.led = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign led = s.led;

    AST_PRE_SHORT: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(s.st == relay_pkg::FS_PRE_ON) |-> s.led [*1] ##1 (s.led || s.st != relay_pkg::FS_PRE_ON))
        else $error("preamble flash not lit");
    AST_ZERO_SIXTEEN: assert property (@(posedge clk) disable iff (!rst_n)
        (s.st == relay_pkg::FS_DIG_OFF && n.st == relay_pkg::FS_GAP && digit_val == 4'h0) |-> (s.cnt == 5'd16))
        else $error("zero digit not sixteen flashes");
    AST_GAP_DARK: assert property (@(posedge clk) disable iff (!rst_n)
        (s.st == relay_pkg::FS_GAP) |-> !s.led)
        else $error("led lit in digit gap");
    AST_DIG_LIMIT: assert property (@(posedge clk) disable iff (!rst_n)
        (s.st == relay_pkg::FS_GAP && n.st == relay_pkg::FS_DIG_ON) |-> ((({1'b0, s.dig} + 3'h1) < err.len)
        && (s.dig < 2'h3) && (s.cnt <= 5'd16)))
        else $error("digit or flash count out of range");
endmodule // flash_coder

// ===== verilog/safety_relay_status.sv
`timescale 1ns/1ps
`include "relay_defs.svh"
module safety_relay_status #(
    parameter int unsigned SUPPLY_LOSS_CYC = `SUPPLY_LOSS_CYC,
    parameter int unsigned POWER_OFF_CYC = `POWER_OFF_CYC,
    parameter int unsigned INIT_CYC = `INIT_CYC,
    parameter int unsigned BLINK_HALF_CYC = `BLINK_HALF_CYC,
    parameter int unsigned TEST_PERIOD_CYC = `TEST_PERIOD_CYC,
    parameter int unsigned TEST_PULSE_CYC = `TEST_PULSE_CYC,
    parameter int unsigned SHORT_CYC = `SHORT_FLASH_CYC,
    parameter int unsigned PAUSE_CYC = `PREAMBLE_PAUSE_CYC,
    parameter int unsigned GAP_CYC = `DIGIT_GAP_CYC,
    parameter int unsigned DIGIT_CYC = `DIGIT_FLASH_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic SUPPLY_OK,
    input wire logic MODE_VALID,
    input wire logic INPUT_CH1,
    input wire logic INPUT_CH2,
    input wire logic START_REQ,
    input wire logic FEEDBACK_CLOSED,
    input wire logic OR_LINK_INPUT,
    input wire logic AND_LINK_INPUT,
    input wire logic DELAY_DONE,
    input wire logic FAULT_VALID,
    input wire relay_pkg::err_code_t FAULT_CODE,
    output logic SAFE_OUT_INST,
    output logic SAFE_OUT_DELAYED,
    output logic DELAY_RUN,
    output logic DELAY_CUT,
    output logic POWER_LED,
    output logic CHANNEL_ONE_LED,
    output logic CHANNEL_TWO_LED
);
    typedef struct packed {
        logic [1:0] sup_s;
        logic [1:0] in1_s;
        logic [1:0] in2_s;
        logic [1:0] st_s;
        logic [1:0] fb_s;
        logic [1:0] or_s;
        logic [1:0] and_s;
        logic [1:0] dd_s;
        logic [1:0] mv_s;
        relay_pkg::mode_t mode;
        logic [31:0] loss_tmr;
        logic [31:0] off_tmr;
        logic [31:0] init_tmr;
        logic [31:0] blink_tmr;
        logic blink;
        logic [31:0] test_tmr;
        logic test_gap;
        logic start_saved;
        logic delayed_on;
        relay_pkg::err_code_t err;
        logic out_inst;
        logic out_del;
        relay_pkg::leds_t leds;
    } top_t;
    top_t s, n;
    logic code_led;
    logic enable;
    logic sup, in1, in2, stq, fb, orl, andl, dd, mv;
    logic both_closed, one_open;

    // ****************************************************************
    // flash-code sequencer
    // ****************************************************************
    flash_coder #(
        .SHORT_CYC(SHORT_CYC),
        .PAUSE_CYC(PAUSE_CYC),
        .GAP_CYC(GAP_CYC),
        .DIGIT_CYC(DIGIT_CYC)
    ) u_coder (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .run(s.mode == relay_pkg::ST_CODE || s.mode == relay_pkg::ST_LOCKED),
        .err(s.err),
        .led(code_led),
        .frame_start()
    );

    // ****************************************************************
    // synchronised pin views
    // ****************************************************************
    assign sup = s.sup_s[1];
    assign in1 = s.in1_s[1];
    assign in2 = s.in2_s[1];
    assign stq = s.st_s[1];
    assign fb = s.fb_s[1];
    assign orl = s.or_s[1];
    assign andl = s.and_s[1];
    assign dd = s.dd_s[1];
    assign mv = s.mv_s[1];
    assign both_closed = in1 && in2;
    assign one_open = in1 ^ in2;
    // OR link mutes the input circuit, AND link gates the whole enable term
    assign enable = (both_closed || orl) && andl;

    // next-state logic
    always_comb begin
        n = s;
        n.sup_s = {s.sup_s[0], SUPPLY_OK};
        n.in1_s = {s.in1_s[0], INPUT_CH1};
        n.in2_s = {s.in2_s[0], INPUT_CH2};
        n.st_s = {s.st_s[0], START_REQ};
        n.fb_s = {s.fb_s[0], FEEDBACK_CLOSED};
        n.or_s = {s.or_s[0], OR_LINK_INPUT};
        n.and_s = {s.and_s[0], AND_LINK_INPUT};
        n.dd_s = {s.dd_s[0], DELAY_DONE};
        n.mv_s = {s.mv_s[0], MODE_VALID};
        // blink base for periodic patterns
        if (s.blink_tmr == 32'h0) begin
            n.blink_tmr = BLINK_HALF_CYC - 1;
            n.blink = !s.blink;
        end else begin
            n.blink_tmr = s.blink_tmr - 32'h1;
        end
        // test pulse generator
        if (s.test_tmr == 32'h0) begin
            n.test_tmr = TEST_PERIOD_CYC - 1;
        end else begin
            n.test_tmr = s.test_tmr - 32'h1;
        end
        n.test_gap = (s.test_tmr < TEST_PULSE_CYC);
        // supply loss timers
        n.loss_tmr = sup ? 32'h0 : ((s.loss_tmr < SUPPLY_LOSS_CYC) ? s.loss_tmr + 32'h1 : s.loss_tmr);
        n.off_tmr = sup ? 32'h0 : ((s.off_tmr < POWER_OFF_CYC) ? s.off_tmr + 32'h1 : s.off_tmr);
        if (s.init_tmr != 32'h0) begin
            n.init_tmr = s.init_tmr - 32'h1;
        end
        unique case (s.mode)
            relay_pkg::ST_INIT: begin
                if (s.init_tmr == 32'h0 && mv) begin
                    n.mode = relay_pkg::ST_WAIT_START;
                end
            end
            relay_pkg::ST_WAIT_START: begin
                if (!fb && stq) begin
                    n.mode = relay_pkg::ST_ALT;
                end else if (one_open) begin
                    n.mode = relay_pkg::ST_ALT;
                end else if (enable && !s.delayed_on && (stq || s.start_saved)) begin
                    n.mode = relay_pkg::ST_RUN;
                end
            end
            relay_pkg::ST_RUN: begin
                if (!enable) begin
                    n.mode = relay_pkg::ST_WAIT_START;
                end
            end
            relay_pkg::ST_ALT: begin
                if (fb && !in1 && !in2) begin
                    n.mode = relay_pkg::ST_WAIT_START;
                end
            end
            relay_pkg::ST_CODE: begin
                if (!sup) begin
                    n.mode = relay_pkg::ST_LOCKED;
                end
            end
            relay_pkg::ST_LOCKED: begin
                if (sup && s.off_tmr >= POWER_OFF_CYC) begin
                    n.mode = relay_pkg::ST_INIT;
                    n.init_tmr = INIT_CYC - 1;
                end
            end
            default: n.mode = relay_pkg::ST_INIT;
        endcase
        // delayed channel off-delay with stored start
        if (s.mode == relay_pkg::ST_RUN && enable) begin
            n.delayed_on = 1'b1;
            n.start_saved = 1'b0;
        end else if (s.delayed_on && dd) begin
            n.delayed_on = 1'b0;
        end
        if (s.delayed_on && s.mode != relay_pkg::ST_RUN && stq && enable) begin
            n.start_saved = 1'b1;
        end
        if (!s.delayed_on && s.start_saved && s.mode == relay_pkg::ST_RUN) begin
            n.start_saved = 1'b0;
        end
        // faults override every mode but ST_LOCKED and ST_CODE
        if (s.mode != relay_pkg::ST_LOCKED && s.mode != relay_pkg::ST_CODE) begin
            if (s.loss_tmr >= SUPPLY_LOSS_CYC) begin
                n.mode = relay_pkg::ST_LOCKED;
                n.err = '{code: `SUPPLY_ERR_CODE, len: `SUPPLY_ERR_LEN};
            end else if (FAULT_VALID) begin
                n.mode = relay_pkg::ST_CODE;
                n.err = FAULT_CODE;
            end
        end
        if (n.mode == relay_pkg::ST_CODE || n.mode == relay_pkg::ST_LOCKED) begin
            n.delayed_on = 1'b0;
            n.start_saved = 1'b0;
        end
        n.out_inst = (n.mode == relay_pkg::ST_RUN) && !n.test_gap;
        n.out_del = n.delayed_on && !n.test_gap;
        // LED patterns
        unique case (n.mode)
            relay_pkg::ST_INIT, relay_pkg::ST_WAIT_START: n.leds = '{power: n.blink, ch1: 1'b0,
                                                                     ch2: n.delayed_on};
            relay_pkg::ST_ALT: n.leds = '{power: 1'b1, ch1: n.blink, ch2: !n.blink};
            relay_pkg::ST_CODE, relay_pkg::ST_LOCKED: n.leds = '{power: 1'b1, ch1: code_led, ch2: 1'b0};
            default: n.leds = '{power: 1'b1, ch1: n.out_inst | n.test_gap & (n.mode == relay_pkg::ST_RUN),
                                ch2: n.delayed_on};
        endcase
        if (!mv && n.mode == relay_pkg::ST_INIT) begin
            n.leds.power = n.blink;
        end
    end

    // state register
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            s <= '0;
            s.init_tmr <= INIT_CYC - 1;
        end else begin
            s <= n;
        end
    end

    assign SAFE_OUT_INST = s.out_inst;
    assign SAFE_OUT_DELAYED = s.out_del;
    assign DELAY_RUN = s.delayed_on && s.mode != relay_pkg::ST_RUN;
    assign DELAY_CUT = (s.mode == relay_pkg::ST_CODE || s.mode == relay_pkg::ST_LOCKED);
    assign POWER_LED = s.leds.power;
    assign CHANNEL_ONE_LED = s.leds.ch1;
    assign CHANNEL_TWO_LED = s.leds.ch2;

    sequence seq_locked;
        s.mode == relay_pkg::ST_LOCKED;
    endsequence
    AST_LOSS_OFF: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        seq_locked |-> !SAFE_OUT_INST && !SAFE_OUT_DELAYED)
        else $error("outputs high while locked");
    AST_LOCK_HOLD: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        seq_locked ##1 (s.mode != relay_pkg::ST_LOCKED) |-> $past(s.off_tmr) >= POWER_OFF_CYC)
        else $error("lock left without power-off time");
    AST_AND_LOW: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        !andl |-> ##1 !SAFE_OUT_INST)
        else $error("instant output high with AND link low");
    AST_CH1_LED: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (s.mode == relay_pkg::ST_RUN && SAFE_OUT_INST) |-> CHANNEL_ONE_LED)
        else $error("channel one led off with output high");
    AST_CH2_LED: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (s.mode != relay_pkg::ST_ALT && SAFE_OUT_DELAYED) |-> CHANNEL_TWO_LED)
        else $error("channel two led off with output high");
    AST_ALT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (s.mode == relay_pkg::ST_ALT) |-> (CHANNEL_ONE_LED != CHANNEL_TWO_LED))
        else $error("channel leds not alternating");
    AST_POWER_STEADY: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (s.mode == relay_pkg::ST_RUN) |-> POWER_LED)
        else $error("power led not steady when ready");
    AST_TEST_GAP: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        s.test_gap |-> !SAFE_OUT_INST && !SAFE_OUT_DELAYED)
        else $error("output high during test pulse");
endmodule // safety_relay_status

// ===== tb/link_unit_model.sv
`timescale 1ns/1ps
// ****************************************************************
// upstream safety unit driving one logic link input
// ****************************************************************
module link_unit_model (
    input wire logic clk,
    input wire logic enable,
    input wire logic contact_open,
    output logic safe_out
);
    initial safe_out = 1'b0;
    // safety output follows the unit's own state, an interrupting contact cuts it
    always_ff @(posedge clk) begin
        safe_out <= enable & ~contact_open;
    end
endmodule // link_unit_model

// ===== tb/safety_relay_status_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) chk(nm, (e) === (g), e, g)
module safety_relay_status_tb;
    // ****************************************************************
    // shortened timing and stimulus
    // ****************************************************************
    localparam int SHORT = 4;
    localparam int DIGIT = 16;
    typedef struct {logic ch1; logic ch2; logic orl; logic andl; logic out;} row_t;
    logic sys_clk, rst_n, supply_ok, mode_valid, in_ch1, in_ch2, start_req, fb_closed, delay_done, fault_valid;
    logic or_en, and_en, and_cut, or_link, and_link;
    logic safe_inst, safe_dly, delay_run, delay_cut, power_led, ch1_led, ch2_led;
    relay_pkg::err_code_t fault_code;
    int fail_count = 0;
    int compares = 0;
    logic [7:0] seen;
    int on_q[$];
    int off_q[$];
    row_t rows[4] = '{'{1, 1, 0, 1, 1}, '{1, 1, 0, 0, 0}, '{0, 0, 1, 1, 1}, '{0, 0, 0, 1, 0}};
    safety_relay_status #(.SUPPLY_LOSS_CYC(20), .POWER_OFF_CYC(50), .INIT_CYC(10), .BLINK_HALF_CYC(4),
        .TEST_PERIOD_CYC(40), .TEST_PULSE_CYC(2), .SHORT_CYC(SHORT), .PAUSE_CYC(10), .GAP_CYC(15),
        .DIGIT_CYC(DIGIT)) i_safety_relay_status (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .SUPPLY_OK(supply_ok), .MODE_VALID(mode_valid),
        .INPUT_CH1(in_ch1), .INPUT_CH2(in_ch2), .START_REQ(start_req), .FEEDBACK_CLOSED(fb_closed),
        .OR_LINK_INPUT(or_link), .AND_LINK_INPUT(and_link), .DELAY_DONE(delay_done),
        .FAULT_VALID(fault_valid), .FAULT_CODE(fault_code), .SAFE_OUT_INST(safe_inst),
        .SAFE_OUT_DELAYED(safe_dly), .DELAY_RUN(delay_run), .DELAY_CUT(delay_cut),
        .POWER_LED(power_led), .CHANNEL_ONE_LED(ch1_led), .CHANNEL_TWO_LED(ch2_led)
    );
    // OR link on the first link input, AND link on the second
    // one interrupting contact line runs through both link connections
    link_unit_model i_link_unit_model_or (.clk(sys_clk), .enable(or_en), .contact_open(and_cut),
        .safe_out(or_link));
    link_unit_model i_link_unit_model_and (.clk(sys_clk), .enable(and_en), .contact_open(and_cut),
        .safe_out(and_link));
    // ****************************************************************
    // helpers
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(string nm, bit ok, logic [31:0] e, logic [31:0] g);
        compares++;
        if (!ok) begin
            fail_count++;
            $display("BAD %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // collects seen flags: out, dly, led1, led2, power high, power low, both leds high, led2 dark with dly high
    task automatic watch(int n);
        seen = '0;
        repeat (n) begin
            step(1);
            seen |= {1'b0, ch1_led & ch2_led, ~power_led, power_led, ch2_led, ch1_led, safe_dly, safe_inst};
            if (safe_dly === 1'b1 && ch2_led !== 1'b1) seen[7] = 1'b1;
        end
    endtask
    task automatic press_start();
        start_req = 1'b1;
        step(4);
        start_req = 1'b0;
        step(10);
    endtask
    task automatic wait_out();
        int k;
        for (k = 0; k < 200 && safe_inst !== 1'b1; k++) step(1);
        if (k == 200) begin
            chk("wait_out", 1'b0, 1, 0);
            report_and_stop();
        end
    endtask
    task automatic open_all();
        in_ch1 = 1'b0;
        in_ch2 = 1'b0;
        or_en = 1'b0;
        and_en = 1'b1;
        fb_closed = 1'b1;
        step(30);
    endtask
    // expected on-time of flash i for code 1,0: preamble, one, sixteen, next preamble
    function automatic int exp_on(int i);
        return (i < 3 || i > 19) ? SHORT : DIGIT / 2;
    endfunction
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        int run_len;
        int dark;
        rst_n = 1'b0;
        supply_ok = 1'b1;
        mode_valid = 1'b0;
        in_ch1 = 1'b0;
        in_ch2 = 1'b0;
        start_req = 1'b0;
        fb_closed = 1'b1;
        delay_done = 1'b1;
        fault_valid = 1'b0;
        fault_code = '0;
        or_en = 1'b0;
        and_en = 1'b1;
        and_cut = 1'b0;
        watch(16);
        `CHK("reset_outputs", 8'h20, seen);
        rst_n = 1'b1;
        watch(8);
        `CHK("init_blink", 2'h3, seen[5:4]);
        // unknown mode: a start with closed inputs is refused
        {in_ch1, in_ch2} = 2'h3;
        press_start();
        watch(40);
        `CHK("unknown_mode_blink", 2'h3, seen[5:4]);
        `CHK("unknown_mode_off", 1'b0, seen[0]);
        mode_valid = 1'b1;
        watch(40);
        `CHK("start_pending_blink", 2'h3, seen[5:4]);
        // link and input combinations, each started from open inputs
        foreach (rows[r]) begin
            open_all();
            {in_ch1, in_ch2, or_en, and_en} = {rows[r].ch1, rows[r].ch2, rows[r].orl, rows[r].andl};
            step(10);
            press_start();
            watch(60);
            `CHK("row_out", rows[r].out, seen[0]);
            `CHK("row_led1", rows[r].out, seen[2]);
            `CHK("row_led2_track", 1'b0, seen[7]);
            if (rows[r].out) begin
                `CHK("power_steady", 2'h1, seen[5:4]);
            end
        end
        // running with both channels closed, then an interrupting contact on the AND link
        open_all();
        {in_ch1, in_ch2} = 2'h3;
        step(10);
        press_start();
        wait_out();
        watch(40);
        `CHK("run_led1_lit", 1'b1, seen[2]);
        run_len = 0;
        dark = 0;
        for (int k = 0; k < 45; k++) begin
            step(1);
            if (safe_inst === 1'b0) run_len++;
            if (safe_dly === 1'b0) dark++;
        end
        `CHK("test_pulse", 1'b1, dark > 0 && dark < 20);
        `CHK("test_pulse_seen", 1'b1, run_len > 0 && run_len < 20);
        and_cut = 1'b1;
        watch(40);
        step(10);
        `CHK("and_cut_out", 1'b0, safe_inst);
        and_cut = 1'b0;
        // off-delay held open, a start pressed while it runs is stored until expiry
        step(10);
        delay_done = 1'b0;
        press_start();
        wait_out();
        {in_ch1, in_ch2} = 2'h0;
        step(6);
        `CHK("delay_run", 1'b1, delay_run);
        `CHK("delay_led2", 1'b1, ch2_led);
        {in_ch1, in_ch2} = 2'h3;
        step(6);
        press_start();
        `CHK("start_held", 1'b1, delay_run);
        delay_done = 1'b1;
        wait_out();
        `CHK("start_stored", 1'b0, delay_run);
        // alternate flashing: one channel open, then feedback open at start-up
        for (int c = 0; c < 2; c++) begin
            open_all();
            {in_ch1, in_ch2} = 2'h3;
            step(10);
            fb_closed = (c == 0);
            press_start();
            if (c == 0) in_ch2 = 1'b0;
            step(10);
            watch(60);
            `CHK("alt_leds", 2'h3, seen[3:2]);
            `CHK("alt_no_overlap", 1'b0, seen[6] & ch1_led & ch2_led);
        end
        // supply interruption locks, a short off does not clear, a long off does
        open_all();
        {in_ch1, in_ch2} = 2'h3;
        step(10);
        press_start();
        wait_out();
        supply_ok = 1'b0;
        step(30);
        supply_ok = 1'b1;
        watch(60);
        `CHK("loss_out", 1'b0, seen[0]);
        `CHK("loss_led", 1'b1, seen[2]);
        supply_ok = 1'b0;
        step(10);
        supply_ok = 1'b1;
        step(10);
        press_start();
        watch(40);
        `CHK("lock_holds", 1'b0, seen[0]);
        supply_ok = 1'b0;
        step(60);
        supply_ok = 1'b1;
        watch(12);
        `CHK("restart_blink", 2'h3, seen[5:4]);
        step(30);
        press_start();
        wait_out();
        // coded fault 1,0 recorded as flash on-times and dark gaps
        fault_code = '{code: 16'h1000, len: 3'h2};
        fault_valid = 1'b1;
        step(1);
        fault_valid = 1'b0;
        `CHK("fault_out", 1'b0, safe_inst);
        `CHK("fault_dly", 1'b0, safe_dly);
        `CHK("fault_delay_cut", 1'b1, delay_cut);
        run_len = 0;
        dark = 0;
        repeat (900) begin
            step(1);
            if (ch1_led === 1'b1) begin
                if (run_len == 0 && on_q.size() > 0) off_q.push_back(dark);
                run_len++;
                dark = 0;
            end else begin
                if (run_len > 0) on_q.push_back(run_len);
                run_len = 0;
                dark++;
            end
        end
        `CHK("flash_count", 1'b1, on_q.size() >= 23);
        if (on_q.size() >= 23) begin
            for (int i = 0; i < 23; i++) `CHK("flash_len", exp_on(i), on_q[i]);
            `CHK("pause_longer", 1'b1, off_q[2] > SHORT);
            `CHK("digit_gap", 1'b1, off_q[3] > off_q[4]);
            `CHK("repeat_gap", 1'b1, off_q[19] > off_q[18]);
        end
        report_and_stop();
    end
endmodule // safety_relay_status_tb
